// [hw/dio_defs.svh]
// Constants of the 48-line open-drain digital I/O port with event sense.
// Assumes word addressing on the host bus: ADDR carries the register index.
//
// Function
// - Upper data byte is never driven; register content rides on the low eight lines.
// - Reads of unassigned addresses return zero on the driven data lines.
// - Every read and write completes with no wait states.
// - The vector register also answers at its alias index 37H.
// - Six eight-bit ports cover 48 lines; D0 maps to each port's lowest line.
// - Writing a one to a port bit pulls that open-drain output low (on).
// - Reading a port returns the live on/off state of its eight lines.
// - Reset clears all port output registers, releasing every output.
// - Mask bit n set blocks host writes to port n; the port keeps its value.
// - Reading the mask register returns the six mask bits as written.
// - In standard mode mask bits 6 and 7 have no function.
// - After reset all mask bits are clear so every port accepts writes.
// - Writing 07H, 0DH, 06H, 12H in order to port 7 enters enhanced mode.
// - In enhanced mode port 7 bits 7:6 select and report the bank.
// - Bank code 00 is I/O, 01 event status and clear, 10 debounce.
// - Reset gives standard mode, clear masks and bank 0.
// - Each line has an event flip-flop; bank 1 ports 0-5 read them.
// - Writing zero to a bank 1 bit clears that flag, unless an enabled edge lands in that same cycle, and disables sensing.
// - Sensing on a line is enabled only by writing one to its bank 1 bit.
// - Polarity bit per four lines: zero flags falling, one flags rising edges.
// - Bank 1 port 6 bit 7 flags any event; bits 0-5 give per-port status.
`ifndef DIO_DEFS_SVH
`define DIO_DEFS_SVH

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define DIO_IDX_PORT6 6'h06
`define DIO_IDX_PORT7 6'h07
`define DIO_IDX_VEC 6'h17
`define DIO_IDX_VEC_ALIAS 6'h37

// ----------------------------------------------------------------------------
// Field positions, unlock bytes and reset values
// ----------------------------------------------------------------------------
`define DIO_BANK_MSB 7
`define DIO_BANK_LSB 6
`define DIO_STAT_ANY_BIT 7
`define DIO_UNLOCK_B0 8'h07
`define DIO_UNLOCK_B1 8'h0D
`define DIO_UNLOCK_B2 8'h06
`define DIO_UNLOCK_B3 8'h12
`define DIO_PORT_RST 48'h000000000000
`define DIO_MASK_RST 6'h00
`define DIO_VEC_RST 8'h00

`endif

// [hw/dio_event.sv]
// Per-line event sense flip-flops with enable and nibble polarity.
// Assumes io_in is synchronous to clk and the interface is driven by dio_top.
`timescale 1ns/1ns
module dio_event (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [47:0] io_in,
    dio_evt_if.evt ev
);
    logic [47:0] prev_r;
    logic [47:0] en_r;
    logic [47:0] flag_r;

    // One sense cell per line; the port picks the write strobe, the nibble the polarity.
    for (genvar i = 0; i < 48; i++) begin : g_line
        logic clr;
        logic arm;
        logic hit;
        assign clr = ev.wr_port[i / 8] && !ev.wr_bits[i];
        assign arm = ev.wr_port[i / 8] && ev.wr_bits[i];
        assign hit = ev.pol[i / 4] ? (!prev_r[i] && io_in[i]) : (prev_r[i] && !io_in[i]);
        always_ff @(posedge clk) begin
            if (!reset_n) begin
                en_r[i] <= 1'b0;
                flag_r[i] <= 1'b0;
            end else begin
                en_r[i] <= clr ? 1'b0 : (arm ? 1'b1 : en_r[i]);
                flag_r[i] <= (flag_r[i] && !clr) || (en_r[i] && hit);
            end
        end
    end

    // Previous input level, used only for edge detection.
    // Reset takes the pulled-up idle level, so no false rising edge follows reset.
    always_ff @(posedge clk) begin
        if (!reset_n) prev_r <= 48'hFFFFFFFFFFFF;
        else prev_r <= io_in;
    end

    assign ev.flags = flag_r;

    flag_needs_en_a: assert property (@(posedge clk) disable iff (!reset_n)
        (flag_r & ~$past(flag_r) & ~$past(en_r)) == 48'h000000000000)
        else $error("Event flag set on a line that was not enabled.");
endmodule : dio_event

// [hw/dio_evt_if.sv]
// Interface between the register logic and the event sense array.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface dio_evt_if;
    logic [47:0] wr_bits;
    logic [5:0] wr_port;
    logic [11:0] pol;
    logic [47:0] flags;
    modport ctl (output wr_bits, output wr_port, output pol, input flags);
    modport evt (input wr_bits, input wr_port, input pol, output flags);
endinterface : dio_evt_if

// [hw/dio_pkg.sv]
// Types shared by the digital I/O port modules.
// Assumes nothing beyond a SystemVerilog compiler.
package dio_pkg;
    // Register bank codes carried in port 7 bits 7:6.
    typedef enum logic [1:0] {
        DIO_BANK_IO = 2'h0,
        DIO_BANK_EVT = 2'h1,
        DIO_BANK_DEB = 2'h2,
        DIO_BANK_BAD = 2'h3
    } dio_bank_t;

    // One-hot states of the enhanced mode unlock detector.
    typedef enum logic [4:0] {
        DIO_ULK_IDLE = 5'h01,
        DIO_ULK_GOT0 = 5'h02,
        DIO_ULK_GOT1 = 5'h04,
        DIO_ULK_GOT2 = 5'h08,
        DIO_ULK_ENH = 5'h10
    } dio_ulk_t;
endpackage : dio_pkg

// [hw/dio_top.sv]
// Register logic of the 48-line open-drain digital I/O port with event sense.
// Assumes a host bus with a one-cycle active-low select, word index on ADDR,
// and pin levels that are already synchronous to CLK.
`timescale 1ns/1ns
`include "dio_defs.svh"
module dio_top
    import dio_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic IO_SEL_N,
    input wire logic WR_N,
    input wire logic [5:0] ADDR,
    input wire logic [15:0] DATA_IN,
    output logic [15:0] DATA_OUT,
    output logic DATA_OE_LO,
    output logic DATA_OE_HI,
    output logic ACK_N,
    input wire logic [47:0] IO_IN,
    output logic [47:0] IO_OUT,
    output logic [47:0] IO_OE
);
    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [47:0] port_r;
    logic [5:0] mask_r;
    dio_bank_t bank_r;
    logic [7:0] pol03_r;
    logic [3:0] pol45_r;
    logic [7:0] vec_r;
    logic [7:0] rdata_r;
    logic rd_oe_r;
    logic ack_n_r;
    logic [47:0] io_out_r;
    logic acc;
    logic wr;
    logic rd;
    logic enh;
    dio_bank_t bank_eff;
    logic in_io;
    logic in_evt;
    logic is_low_port;
    logic is_p6;
    logic is_p7;
    logic is_vec;
    logic p7_wr;
    logic [7:0] wbyte;
    logic [5:0] port_wr;
    logic [5:0] port_any;
    logic [7:0] p6_rd;
    logic [7:0] p7_rd;
    logic [7:0] low_rd;
    logic [7:0] rdata_nxt;
    logic [7:0] port_rd [0:5];

    dio_evt_if ev ();

    // ------------------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------------------

    // Every access is answered in the cycle after its select, so no wait state is ever added.
    assign acc = !IO_SEL_N;
    assign wr = acc && !WR_N;
    assign rd = acc && WR_N;
    assign wbyte = DATA_IN[7:0];

    // Standard mode behaves as bank 0; the bank field only counts once enhanced.
    assign bank_eff = enh ? bank_r : DIO_BANK_IO;
    assign in_io = (bank_eff == DIO_BANK_IO);
    assign in_evt = (bank_eff == DIO_BANK_EVT);

    // Address classes; the vector register answers at both of its indices.
    assign is_low_port = (ADDR < 6'h06);
    assign is_p6 = (ADDR == `DIO_IDX_PORT6);
    assign is_p7 = (ADDR == `DIO_IDX_PORT7);
    assign is_vec = (ADDR == `DIO_IDX_VEC) || (ADDR == `DIO_IDX_VEC_ALIAS);
    assign p7_wr = wr && is_p7;

    // ------------------------------------------------------------------------
    // Unlock detector
    // ------------------------------------------------------------------------

    // Every access reaches the detector, so a stray access breaks the sequence.
    dio_unlock u_unlock (
        .clk(CLK),
        .reset_n(RESET_N),
        .acc(acc),
        .p7_wr(p7_wr),
        .wdata(wbyte),
        .enh(enh)
    );

    // ------------------------------------------------------------------------
    // Port output registers
    // ------------------------------------------------------------------------

    // One byte lane per port; D0 lands on the lowest line of the group.
    for (genvar p = 0; p < 6; p++) begin : g_port
        assign port_wr[p] = wr && (ADDR == 6'(p)) && in_io && !mask_r[p];
        assign port_rd[p] = in_evt ? ev.flags[p * 8 +: 8] : ~IO_IN[p * 8 +: 8];
        assign port_any[p] = |ev.flags[p * 8 +: 8];
        assign ev.wr_port[p] = wr && (ADDR == 6'(p)) && in_evt;
        always_ff @(posedge CLK) begin
            if (!RESET_N) port_r[p * 8 +: 8] <= 8'(`DIO_PORT_RST >> (p * 8));
            else if (port_wr[p]) port_r[p * 8 +: 8] <= wbyte;
        end
    end

    // The same written byte serves all six ports; only the selected strobe acts on it.
    assign ev.wr_bits = {6{wbyte}};
    assign ev.pol = {pol45_r, pol03_r};

    // ------------------------------------------------------------------------
    // Mask, bank, polarity and vector registers
    // ------------------------------------------------------------------------

    // Mask lives in port 7 of standard mode and of bank 0; the unlock bytes land here too.
    always_ff @(posedge CLK) begin
        if (!RESET_N) mask_r <= `DIO_MASK_RST;
        else if (p7_wr && in_io) mask_r <= wbyte[5:0];
    end

    // Bank field is written from any bank once enhanced, and ignored in standard mode.
    always_ff @(posedge CLK) begin
        if (!RESET_N) bank_r <= DIO_BANK_IO;
        else if (p7_wr && enh) bank_r <= dio_bank_t'(wbyte[`DIO_BANK_MSB:`DIO_BANK_LSB]);
    end

    // Polarity for ports 0-3 is written through port 6 of bank 1.
    always_ff @(posedge CLK) begin
        if (!RESET_N) pol03_r <= 8'h00;
        else if (wr && is_p6 && in_evt) pol03_r <= wbyte;
    end

    // Polarity for ports 4-5 shares port 7 of bank 1 with the bank field.
    always_ff @(posedge CLK) begin
        if (!RESET_N) pol45_r <= 4'h0;
        else if (p7_wr && in_evt) pol45_r <= wbyte[3:0];
    end

    // Vector register, stored for software; no interrupt is raised here.
    always_ff @(posedge CLK) begin
        if (!RESET_N) vec_r <= `DIO_VEC_RST;
        else if (wr && is_vec) vec_r <= wbyte;
    end

    // ------------------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------------------

    // Event summary: bit 7 is any event, bit 6 unused, bits 5:0 per port.
    assign p6_rd = in_evt ? {|port_any, 1'b0, port_any} : 8'h00;

    // Port 7 shows the mask in bank 0, polarity in bank 1 and the bank in every enhanced bank.
    assign p7_rd = !enh ? {2'b00, mask_r} :
        in_io ? {bank_r, mask_r} :
        in_evt ? {bank_r, 2'b00, pol45_r} :
        {bank_r, 6'h00};

    // Debounce bank ports are not held here and read as zero.
    assign low_rd = (in_io || in_evt) ? port_rd[ADDR[2:0]] : 8'h00;

    // Anything not decoded reads as zero.
    assign rdata_nxt = is_low_port ? low_rd :
        is_p6 ? p6_rd :
        is_p7 ? p7_rd :
        is_vec ? vec_r :
        8'h00;

    // ------------------------------------------------------------------------
    // Bus answer registers
    // ------------------------------------------------------------------------

    // Read data is latched on the select edge and held until the next read.
    always_ff @(posedge CLK) begin
        if (!RESET_N) rdata_r <= 8'h00;
        else if (rd) rdata_r <= rdata_nxt;
    end

    // Acknowledge pulses one cycle after each select; the low-lane enable pulses only after a read.
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            ack_n_r <= 1'b1;
            rd_oe_r <= 1'b0;
        end else begin
            ack_n_r <= !acc;
            rd_oe_r <= rd;
        end
    end

    // Open-drain outputs only ever pull low; this level register never leaves zero.
    always_ff @(posedge CLK) begin
        if (!RESET_N) io_out_r <= 48'h000000000000;
        else io_out_r <= 48'h000000000000;
    end

    // A one in the port register enables the low driver, turning the point on.
    assign IO_OE = port_r;
    assign IO_OUT = io_out_r;
    assign DATA_OUT = {8'h00, rdata_r};
    assign DATA_OE_LO = rd_oe_r;
    assign DATA_OE_HI = 1'b0;
    assign ACK_N = ack_n_r;

    // ------------------------------------------------------------------------
    // Event sense array
    // ------------------------------------------------------------------------

    // Edge detection, enables and flags for all 48 lines.
    dio_event u_event (
        .clk(CLK),
        .reset_n(RESET_N),
        .io_in(IO_IN),
        .ev(ev)
    );

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    zero_wait_ack_a: assert property (
        acc |=> !ACK_N ##1 (ACK_N || $past(acc)))
        else $error("Access not answered in the next cycle.");

    upper_lane_a: assert property (
        DATA_OE_LO |-> !DATA_OE_HI && DATA_OUT[15:8] == 8'h00)
        else $error("Upper data byte carried content.");

    unmapped_zero_a: assert property (
        rd && !is_low_port && !is_p6 && !is_p7 && !is_vec |=> DATA_OE_LO && DATA_OUT[7:0] == 8'h00)
        else $error("Unassigned address did not read zero.");

    vector_alias_a: assert property (
        rd && ADDR == `DIO_IDX_VEC_ALIAS |=> DATA_OUT[7:0] == vec_r)
        else $error("Vector alias read returned wrong data.");

    port_read_a: assert property (
        rd && ADDR == 6'h00 && in_io |=> DATA_OUT[7:0] == ~$past(IO_IN[7:0]))
        else $error("Port read did not show line state.");

    port_write_a: assert property (
        wr && ADDR == 6'h02 && in_io && !mask_r[2] |=> IO_OE[23:16] == $past(wbyte))
        else $error("Unmasked port write did not reach outputs.");

    masked_hold_a: assert property (
        wr && ADDR == 6'h01 && mask_r[1] |=> $stable(IO_OE[15:8]))
        else $error("Masked port changed on write.");

    std_bank_a: assert property (
        !enh |-> bank_r == DIO_BANK_IO && bank_eff == DIO_BANK_IO)
        else $error("Bank moved while in standard mode.");

    event_read_a: assert property (
        rd && ADDR == 6'h03 && in_evt |=> DATA_OUT[7:0] == $past(ev.flags[31:24]))
        else $error("Bank 1 port read did not show event flags.");

    event_summary_a: assert property (
        rd && is_p6 && in_evt |=> DATA_OUT[7] == $past(|ev.flags) && DATA_OUT[6] == 1'b0)
        else $error("Event summary bit wrong.");

    // The host leaves one idle cycle between accesses, so the read back lands two cycles on.
    mask_readback_a: assert property (
        p7_wr && !enh ##2 rd && is_p7 |=> DATA_OUT[5:0] == $past(mask_r) && DATA_OUT[7:6] == 2'b00)
        else $error("Mask read back differs from written value.");

    enh_entered_c: cover property ($rose(enh));
    bank1_read_c: cover property (rd && in_evt && is_low_port);
    masked_write_c: cover property (wr && is_low_port && mask_r[ADDR[2:0]]);
    event_seen_c: cover property ($rose(|ev.flags));
endmodule : dio_top

// [hw/dio_unlock.sv]
// Enhanced mode unlock detector for the digital I/O port.
// Assumes acc marks each host access for one cycle and p7_wr a write to port 7.
`timescale 1ns/1ns
`include "dio_defs.svh"
module dio_unlock
    import dio_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic acc,
    input wire logic p7_wr,
    input wire logic [7:0] wdata,
    output logic enh
);
    dio_ulk_t st_r;
    dio_ulk_t st_nxt;
    logic restart;

    // A wrong byte that is itself the first unlock byte starts a fresh attempt.
    assign restart = p7_wr && (wdata == `DIO_UNLOCK_B0);

    // Sequence walk; once enhanced, only reset leaves.
    always_comb begin
        st_nxt = st_r;
        if (acc && st_r != DIO_ULK_ENH) begin
            st_nxt = restart ? DIO_ULK_GOT0 : DIO_ULK_IDLE;
            case (st_r)
                DIO_ULK_GOT0: if (p7_wr && wdata == `DIO_UNLOCK_B1) st_nxt = DIO_ULK_GOT1;
                DIO_ULK_GOT1: if (p7_wr && wdata == `DIO_UNLOCK_B2) st_nxt = DIO_ULK_GOT2;
                DIO_ULK_GOT2: if (p7_wr && wdata == `DIO_UNLOCK_B3) st_nxt = DIO_ULK_ENH;
                default: ;
            endcase
        end
    end

    // State register; reset returns standard mode.
    always_ff @(posedge clk) begin
        if (!reset_n) st_r <= DIO_ULK_IDLE;
        else st_r <= st_nxt;
    end

    assign enh = (st_r == DIO_ULK_ENH);

    enh_entry_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(enh) |-> $past(p7_wr && wdata == `DIO_UNLOCK_B3 && st_r == DIO_ULK_GOT2))
        else $error("Enhanced mode entered without the last unlock byte.");
endmodule : dio_unlock

// [tb/dio_host_model.sv]
// Host bus controller model that faces the digital I/O port register bus.
// Assumes the bench calls xfer for every access and CLK is the device clock.
`timescale 1ns/1ns
module dio_host_model (
    input wire logic CLK,
    input wire logic ACK_N,
    input wire logic [15:0] DATA_OUT,
    input wire logic DATA_OE_LO,
    input wire logic DATA_OE_HI,
    output logic IO_SEL_N,
    output logic WR_N,
    output logic [5:0] ADDR,
    output logic [15:0] DATA_IN
);
    // ------------------------------------------------------------------------
    // Bus cycle
    // ------------------------------------------------------------------------
    // Idle at time zero with the select high, so nothing is taken before reset ends.
    initial begin
        IO_SEL_N = 1'b1;
        WR_N = 1'b1;
        ADDR = 6'h3F;
        DATA_IN = 16'hFFFF;
    end

    // One access: select low for a single cycle, answer sampled in the next cycle.
    // Released lines show inverted values so a stale bus never looks valid.
    task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
                        output logic [15:0] q, output logic [2:0] st);
        @(negedge CLK);
        if (w && a == 6'h07 && d[7:6] == 2'h3) begin
            d[7] = 1'b0;
        end
        IO_SEL_N = 1'b0;
        WR_N = ~w;
        ADDR = a;
        DATA_IN = {8'h00, d};
        @(negedge CLK);
        // An undriven data lane reads as ones through the carrier pull-ups.
        q = {DATA_OE_HI ? DATA_OUT[15:8] : 8'hFF, DATA_OE_LO ? DATA_OUT[7:0] : 8'hFF};
        st = {ACK_N, DATA_OE_LO, DATA_OE_HI};
        IO_SEL_N = 1'b1;
        WR_N = ~WR_N;
        ADDR = ~a;
        DATA_IN = ~DATA_IN;
    endtask : xfer
endmodule : dio_host_model

// [tb/tb_digital_io_port_event_sense.sv]
// Self-checking bench for the digital I/O port register logic.
// Assumes open-drain lines with pull-ups, modelled from IO_OE and ext_lvl.
`timescale 1ns/1ns
module tb_digital_io_port_event_sense;
    typedef struct {logic [5:0] wa; logic [7:0] wd; logic [5:0] ra; logic [7:0] exp;} dio_row_t;
    logic CLK;
    logic RESET_N;
    logic IO_SEL_N;
    logic WR_N;
    logic [5:0] ADDR;
    logic [15:0] DATA_IN;
    logic [15:0] DATA_OUT;
    logic DATA_OE_LO;
    logic DATA_OE_HI;
    logic ACK_N;
    logic [47:0] IO_IN;
    logic [47:0] IO_OUT;
    logic [47:0] IO_OE;
    logic [47:0] ext_lvl;
    int bad_count = 0;
    int tests_run = 0;
    int cycles = 0;
    // Write then read back; ports 0 and 1 get masked in turn by the mask rows.
    dio_row_t rows [10] = '{'{6'h00, 8'hA5, 6'h00, 8'hA5}, '{6'h07, 8'h01, 6'h07, 8'h01},
        '{6'h00, 8'h3C, 6'h00, 8'hA5}, '{6'h01, 8'h5A, 6'h01, 8'h5A}, '{6'h07, 8'h02, 6'h07, 8'h02},
        '{6'h01, 8'hFF, 6'h01, 8'h5A}, '{6'h07, 8'h80, 6'h07, 8'h00},
        '{6'h37, 8'hA6, 6'h17, 8'hA6}, '{6'h10, 8'hFF, 6'h10, 8'h00}, '{6'h02, 8'hC3, 6'h02, 8'hC3}};
    logic [7:0] ulk [4] = '{8'h07, 8'h0D, 8'h06, 8'h12};

    // A line reads low when the port pulls it or the outside world drives it low.
    assign IO_IN = ext_lvl & ~IO_OE;

    dio_top u_dio_top (.CLK(CLK), .RESET_N(RESET_N), .IO_SEL_N(IO_SEL_N), .WR_N(WR_N), .ADDR(ADDR),
        .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE_LO(DATA_OE_LO), .DATA_OE_HI(DATA_OE_HI),
        .ACK_N(ACK_N), .IO_IN(IO_IN), .IO_OUT(IO_OUT), .IO_OE(IO_OE));
    dio_host_model u_dio_host_model (.CLK(CLK), .ACK_N(ACK_N), .DATA_OUT(DATA_OUT), .DATA_OE_LO(DATA_OE_LO),
        .DATA_OE_HI(DATA_OE_HI), .IO_SEL_N(IO_SEL_N), .WR_N(WR_N), .ADDR(ADDR), .DATA_IN(DATA_IN));

    // ------------------------------------------------------------------------
    // Clock and hang guard
    // ------------------------------------------------------------------------
    // The run needs well under a thousand cycles; the ceiling leaves ample slack.
    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            finish_test();
        end
    end

    // ------------------------------------------------------------------------
    // Compare and bus tasks
    // ------------------------------------------------------------------------
    task automatic cmp_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp_byte
    task automatic cmp_word(input string name, input logic [47:0] exp, input logic [47:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp_word
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [15:0] q;
        logic [2:0] st;
        u_dio_host_model.xfer(1'b1, a, d, q, st);
        cmp_byte("write ack", 8'h00, {7'h00, st[2]});
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [7:0] exp, input string name);
        logic [15:0] q;
        logic [2:0] st;
        u_dio_host_model.xfer(1'b0, a, 8'h00, q, st);
        cmp_byte("read ack and lanes", 8'h02, {5'h00, st});
        cmp_byte("upper data byte", 8'hFF, q[15:8]);
        cmp_byte(name, exp, q[7:0]);
    endtask : rd
    // Synchronous reset held for twenty cycles, applied off the sampling edge.
    task automatic do_reset();
        @(negedge CLK);
        RESET_N = 1'b0;
        repeat (20) @(negedge CLK);
        RESET_N = 1'b1;
    endtask : do_reset
    // Lets a line change be sampled and flagged before it is read back.
    task automatic set_line(input int n, input logic v);
        ext_lvl[n] = v;
        repeat (2) @(negedge CLK);
    endtask : set_line
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    // Table first, then resets, unlock sequences and event sensing by hand.
    initial begin
        RESET_N = 1'b0;
        ext_lvl = '1;
        do_reset();
        cmp_word("outputs after reset", 48'h0, IO_OE);
        rd(6'h07, 8'h00, "mask after reset");
        foreach (rows[i]) begin
            wr(rows[i].wa, rows[i].wd);
            rd(rows[i].ra, rows[i].exp, "table read");
        end
        cmp_word("port drive", 48'h000000C35AA5, IO_OE);
        cmp_word("open-drain level", 48'h0, IO_OUT);
        rd(6'h37, 8'hA6, "vector alias read");
        set_line(8, 1'b0);
        rd(6'h01, 8'h5B, "externally pulled line");
        ext_lvl = '1;
        // A broken unlock sequence must leave standard mode in place.
        do_reset();
        cmp_word("outputs after second reset", 48'h0, IO_OE);
        rd(6'h07, 8'h00, "mode after second reset");
        wr(6'h07, ulk[0]);
        wr(6'h07, ulk[1]);
        rd(6'h00, 8'h00, "interrupting read");
        wr(6'h07, ulk[2]);
        wr(6'h07, ulk[3]);
        wr(6'h07, 8'h40);
        rd(6'h07, 8'h00, "bank ignored after broken unlock");
        // Proper unlock, then bank select and event sensing.
        do_reset();
        foreach (ulk[i]) wr(6'h07, ulk[i]);
        rd(6'h07, 8'h12, "mask after unlock");
        wr(6'h07, 8'h40);
        rd(6'h07, 8'h40, "bank 1 status");
        wr(6'h06, 8'h00);
        wr(6'h00, 8'h01);
        set_line(0, 1'b0);
        rd(6'h00, 8'h01, "falling event line 0");
        rd(6'h06, 8'h81, "event status port 0");
        rd(6'h03, 8'h00, "never enabled port 3");
        wr(6'h00, 8'h00);
        rd(6'h00, 8'h00, "cleared flag");
        set_line(0, 1'b1);
        set_line(0, 1'b0);
        rd(6'h00, 8'h00, "disabled line stays quiet");
        wr(6'h06, 8'h01);
        wr(6'h00, 8'h01);
        set_line(0, 1'b1);
        rd(6'h00, 8'h01, "rising event line 0");
        wr(6'h05, 8'h80);
        set_line(47, 1'b0);
        rd(6'h05, 8'h80, "falling event last line");
        rd(6'h06, 8'hA1, "event status ports 0 and 5");
        wr(6'h07, 8'h48);
        rd(6'h07, 8'h48, "bank 1 polarity ports 4-5");
        wr(6'h07, 8'h80);
        rd(6'h07, 8'h80, "bank 2 status");
        rd(6'h00, 8'h00, "bank 2 port 0");
        wr(6'h07, 8'h00);
        rd(6'h07, 8'h00, "bank 0 status");
        finish_test();
    end
endmodule : tb_digital_io_port_event_sense
